// File: src/motor_loop_reference_monitor.sv
// APB read-only bank of motor control loop references with interrupts
`timescale 1ns/10ps

module motor_loop_reference_monitor #(
  parameter int ADDR_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              upd_valid,
  input  wire logic [2:0]        upd_sel,
  input  wire logic [31:0]       upd_data,
  output logic                   irq
);

  // ---------------------------------------------------------------
  // Bus state machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,  // Waiting for a setup cycle
    S_FETCH = 3'b010,  // First access cycle, store data arriving
    S_RESP  = 3'b100   // pready high, transfer completes here
  } bus_state_e;

  bus_state_e                           state_q;     // Current bus state
  bus_state_e                           state_d;     // Next bus state
  logic [31:0]                          prdata_q;    // Registered read data
  logic [31:0]                          prdata_d;    // Next read data
  logic                                 pready_q;    // Registered ready
  logic                                 pready_d;    // Next ready
  logic                                 pslverr_q;   // Registered error
  logic                                 pslverr_d;   // Next error
  logic [motor_ref_pkg::EV_W-1:0]       status_q;    // Sticky events
  logic [motor_ref_pkg::EV_W-1:0]       status_d;    // Next events
  logic [motor_ref_pkg::EV_W-1:0]       mask_q;      // Interrupt enables
  logic [motor_ref_pkg::EV_W-1:0]       mask_d;      // Next enables
  logic                                 irq_q;       // Registered interrupt
  logic                                 irq_d;       // Next interrupt

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic [15:0]                          idx;         // Word index of paddr
  logic                                 aligned;     // Low address bits zero
  logic                                 hit_slot;    // Reference register hit
  logic [motor_ref_pkg::SLOT_W-1:0]     slot;        // Slot for that hit
  logic                                 hit_status;  // Status register hit
  logic                                 hit_mask;    // Mask register hit
  logic                                 hit_any;     // Any mapped register

  assign idx     = 16'(paddr[ADDR_W-1:2]);
  assign aligned = (paddr[1:0] == 2'h0);

  // Map index to storage slot
  always_comb
  begin
    hit_slot = aligned;
    slot     = motor_ref_pkg::SLOT_OPEN_LOOP;
    unique case (idx)
      motor_ref_pkg::IDX_OPEN_LOOP_TORQUE: slot = motor_ref_pkg::SLOT_OPEN_LOOP;
      motor_ref_pkg::IDX_CLOSED_SPEED:     slot = motor_ref_pkg::SLOT_SPEED;
      motor_ref_pkg::IDX_FLUX_CURRENT:     slot = motor_ref_pkg::SLOT_FLUX;
      motor_ref_pkg::IDX_TORQUE_CURRENT:   slot = motor_ref_pkg::SLOT_TORQUE;
      motor_ref_pkg::IDX_DETECT_STATE:     slot = motor_ref_pkg::SLOT_DETECT;
      default:                             hit_slot = 1'b0;
    endcase
  end

  assign hit_status = aligned && (idx == motor_ref_pkg::IDX_IRQ_STATUS);
  assign hit_mask   = aligned && (idx == motor_ref_pkg::IDX_IRQ_MASK);
  assign hit_any    = hit_slot || hit_status || hit_mask;

  // ---------------------------------------------------------------
  // Reference store
  // ---------------------------------------------------------------
  logic                                 rd_en;       // Fetch at setup edge
  logic                                 wr_en;       // Algorithm update
  logic [31:0]                          wr_data;     // Update word
  logic [31:0]                          rd_data;     // Store read data

  assign rd_en = (state_q == S_IDLE) && psel && !penable;
  assign wr_en = upd_valid && (int'(upd_sel) < motor_ref_pkg::NUM_SLOTS);

  // State code keeps only its field; the upper half stays zero
  assign wr_data = (upd_sel == motor_ref_pkg::SLOT_DETECT)
                 ? {16'h0000, upd_data[motor_ref_pkg::STATE_W-1:0]}
                 : upd_data;

  ref_store #(
    .WIDTH (32),
    .DEPTH (motor_ref_pkg::NUM_SLOTS),
    .IDX_W (motor_ref_pkg::SLOT_W)
  ) u_store (
    .clk       (pclk),
    .rst_n     (presetn),
    .wr_en     (wr_en),
    .wr_idx    (upd_sel),
    .wr_data   (wr_data),
    .rd_en     (rd_en),
    .rd_idx    (slot),
    .rd_data_q (rd_data)
  );

  // ---------------------------------------------------------------
  // Bus next state and response
  // ---------------------------------------------------------------
  // One wait state: the store answers a cycle after the setup edge
  always_comb
  begin
    state_d   = state_q;
    prdata_d  = motor_ref_pkg::REG_RESET;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    unique case (state_q)
      S_IDLE:
      begin
        if (psel && !penable)
        begin
          state_d = S_FETCH;
        end
      end
      S_FETCH:
      begin
        state_d   = S_RESP;
        pready_d  = 1'b1;
        pslverr_d = !hit_any;
        // Reads only select data; nothing is cleared on read
        if (!pwrite && hit_slot)
        begin
          prdata_d = rd_data;
        end
        else if (!pwrite && hit_status)
        begin
          prdata_d = 32'(status_q);
        end
        else if (!pwrite && hit_mask)
        begin
          prdata_d = 32'(mask_q);
        end
      end
      S_RESP:
      begin
        state_d = S_IDLE;
      end
    endcase
  end

  // Bus registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q   <= S_IDLE;
      prdata_q  <= motor_ref_pkg::REG_RESET;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic                                 wr_fire;     // Write completes now
  logic [motor_ref_pkg::EV_W-1:0]       ev;          // Events this cycle

  assign wr_fire = (state_q == S_RESP) && psel && penable && pwrite;

  // Detection outcome and bus writes to a read-only slot register raise events; unmapped writes raise none
  always_comb
  begin
    ev = '0;
    ev[motor_ref_pkg::EV_DONE_BIT] = wr_en
      && (upd_sel == motor_ref_pkg::SLOT_DETECT)
      && (upd_data[15:0] == motor_ref_pkg::DETECT_DONE);
    ev[motor_ref_pkg::EV_ERROR_BIT] = wr_en
      && (upd_sel == motor_ref_pkg::SLOT_DETECT)
      && (upd_data[15:0] == motor_ref_pkg::DETECT_ERROR);
    ev[motor_ref_pkg::EV_RO_WRITE_BIT] = wr_fire && hit_slot;
  end

  // Write one to clear; a new event in the same cycle still sets
  always_comb
  begin
    status_d = status_q;
    mask_d   = mask_q;
    if (wr_fire && hit_status)
    begin
      status_d = status_q & ~pwdata[motor_ref_pkg::EV_W-1:0];
    end
    if (wr_fire && hit_mask)
    begin
      mask_d = pwdata[motor_ref_pkg::EV_W-1:0];
    end
    status_d = status_d | ev;
    irq_d    = |(status_d & mask_d);
  end

  // Interrupt registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= motor_ref_pkg::EV_RESET;
      mask_q   <= motor_ref_pkg::EV_RESET;
      irq_q    <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic rd_resp;  // Read completing this cycle
  assign rd_resp = (state_q == S_RESP) && psel && penable && !pwrite;

  property p_open_loop_read;
    @(posedge pclk) disable iff (!presetn)
    (rd_resp && hit_slot && slot == motor_ref_pkg::SLOT_OPEN_LOOP)
      |-> prdata == $past(u_store.word_q[0], 2);
  endproperty
  a_open_loop_read: assert property (p_open_loop_read)
    else $error("open loop reference read mismatch");

  property p_speed_read;
    @(posedge pclk) disable iff (!presetn)
    (rd_resp && hit_slot && slot == motor_ref_pkg::SLOT_SPEED)
      |-> prdata == $past(u_store.word_q[1], 2);
  endproperty
  a_speed_read: assert property (p_speed_read)
    else $error("speed reference read mismatch");

  property p_flux_read;
    @(posedge pclk) disable iff (!presetn)
    (rd_resp && hit_slot && slot == motor_ref_pkg::SLOT_FLUX)
      |-> prdata == $past(u_store.word_q[2], 2);
  endproperty
  a_flux_read: assert property (p_flux_read)
    else $error("flux current reference read mismatch");

  property p_torque_read;
    @(posedge pclk) disable iff (!presetn)
    (rd_resp && hit_slot && slot == motor_ref_pkg::SLOT_TORQUE)
      |-> prdata == $past(u_store.word_q[3], 2);
  endproperty
  a_torque_read: assert property (p_torque_read)
    else $error("torque current reference read mismatch");

  property p_state_upper_zero;
    @(posedge pclk) disable iff (!presetn)
    (upd_valid && upd_sel == motor_ref_pkg::SLOT_DETECT && upd_data[15:0] == 16'h0003)
      |=> u_store.word_q[4][31:16] == 16'h0000 && status_q[0];
  endproperty
  a_state_upper_zero: assert property (p_state_upper_zero)
    else $error("detection state stored wrong or done event lost");

  property p_reset_clear;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (prdata == 32'h0000_0000) && !irq && !pready
      && (u_store.word_q[4] == 32'h0000_0000) && (status_q == 3'h0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("register not zero after reset");

  property p_ro_write_ignored;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && hit_slot && !upd_valid)
      |-> !pslverr ##1 ($stable(u_store.word_q[slot]) && status_q[2]);
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored)
    else $error("write to read-only register took effect");

  property p_wait_state;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && state_q == S_IDLE) |=> !pready ##1 pready ##1 !pready;
  endproperty
  a_wait_state: assert property (p_wait_state)
    else $error("ready not given after exactly one wait state");

  c_read_open_loop: cover property (@(posedge pclk) disable iff (!presetn)
    rd_resp && hit_slot && slot == motor_ref_pkg::SLOT_OPEN_LOOP);
  c_detect_error: cover property (@(posedge pclk) disable iff (!presetn)
    ev[motor_ref_pkg::EV_ERROR_BIT]);
  c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule

// File: src/motor_ref_pkg.sv
// Constants for the motor loop reference monitor register bank
// Operation
// - Open-loop torque current reference, read only
// - Closed-loop speed reference, read only
// - Flux-loop d-axis current reference, read only
// - Torque-loop q-axis current reference, read only
// - Detection state in low 16 bits, upper zero
// - Every register reads zero after reset
package motor_ref_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_OPEN_LOOP_TORQUE = 16'h0548;
  localparam logic [15:0] IDX_CLOSED_SPEED     = 16'h05cc;
  localparam logic [15:0] IDX_FLUX_CURRENT     = 16'h05fc;
  localparam logic [15:0] IDX_TORQUE_CURRENT   = 16'h05fe;
  localparam logic [15:0] IDX_DETECT_STATE     = 16'h067a;
  localparam logic [15:0] IDX_IRQ_STATUS       = 16'h0680;
  localparam logic [15:0] IDX_IRQ_MASK         = 16'h0681;

  // ---------------------------------------------------------------
  // Storage slots inside the reference store
  // ---------------------------------------------------------------
  localparam int          NUM_SLOTS            = 5;
  localparam int          SLOT_W               = 3;
  localparam logic [2:0]  SLOT_OPEN_LOOP       = 3'h0;
  localparam logic [2:0]  SLOT_SPEED           = 3'h1;
  localparam logic [2:0]  SLOT_FLUX            = 3'h2;
  localparam logic [2:0]  SLOT_TORQUE          = 3'h3;
  localparam logic [2:0]  SLOT_DETECT          = 3'h4;

  // ---------------------------------------------------------------
  // Detection state field and codes
  // ---------------------------------------------------------------
  localparam int          STATE_W              = 16;
  localparam logic [15:0] DETECT_INIT          = 16'h0000;
  localparam logic [15:0] DETECT_STOP_CHECK    = 16'h0001;
  localparam logic [15:0] DETECT_DIRECTION     = 16'h0002;
  localparam logic [15:0] DETECT_DONE          = 16'h0003;
  localparam logic [15:0] DETECT_ERROR         = 16'h0004;

  // ---------------------------------------------------------------
  // Interrupt event bits and reset values
  // ---------------------------------------------------------------
  localparam int          EV_W                 = 3;
  localparam int          EV_DONE_BIT          = 0;
  localparam int          EV_ERROR_BIT         = 1;
  localparam int          EV_RO_WRITE_BIT      = 2;
  localparam logic [31:0] REG_RESET            = 32'h0000_0000;
  localparam logic [2:0]  EV_RESET             = 3'h0;

endpackage

// File: src/ref_store.sv
// Small reset-to-zero word store with a registered read port
`timescale 1ns/10ps

module ref_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 5,
  parameter int IDX_W = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [WIDTH-1:0] rd_data_q
);

  logic [WIDTH-1:0] word_q [DEPTH];  // Stored words
  logic [WIDTH-1:0] rd_data_d;       // Next read data

  // ---------------------------------------------------------------
  // Storage, one register per entry
  // ---------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_word
    // Only the update port writes; reading never disturbs a word
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        word_q[i] <= '0;
      end
      else if (wr_en && (wr_idx == IDX_W'(i)))
      begin
        word_q[i] <= wr_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Holds last data when idle; out-of-range index reads zero
  always_comb
  begin
    rd_data_d = rd_data_q;
    if (rd_en)
    begin
      rd_data_d = (int'(rd_idx) < DEPTH) ? word_q[rd_idx] : '0;
    end
  end

  // Registered read data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_q <= '0;
    end
    else
    begin
      rd_data_q <= rd_data_d;
    end
  end

endmodule

// File: tb/tb_top.sv
// Self-checking bench for the motor loop reference monitor register bank
`timescale 1ns/10ps

module tb_top;
  // ---------------------------------------------------------------
  // Stimulus signals and bookkeeping
  // ---------------------------------------------------------------
  logic        pclk;          // Bus clock, 20 ns period
  logic        presetn;       // Asynchronous reset, active low
  logic        psel;          // APB select
  logic        penable;       // APB access phase
  logic        pwrite;        // APB direction
  logic [15:0] paddr;         // APB byte address
  logic [31:0] pwdata;        // APB write data
  logic [31:0] prdata;        // APB read data
  logic        pready;        // APB response
  logic        pslverr;       // APB error response
  logic        upd_valid;     // Algorithm update strobe
  logic [2:0]  upd_sel;       // Algorithm update slot
  logic [31:0] upd_data;      // Algorithm update value
  logic        irq;           // Level interrupt
  logic [31:0] rdat;          // Last read data
  logic        rerr;          // Last error flag
  int          fail_count;    // Mismatches seen
  int          total_checks;  // Comparisons made
  int          cycles = 0;    // Clock cycles since start

  motor_loop_reference_monitor #(.ADDR_W(16)) DUT (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .upd_valid (upd_valid),
    .upd_sel   (upd_sel),
    .upd_data  (upd_data),
    .irq       (irq)
  );

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // The whole run needs well under a thousand cycles; a stuck wait ends here
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Printed offsets are word indices, so the byte address is four times that
  function automatic logic [15:0] ba(input logic [15:0] idx);
    return idx << 2;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; pready is sampled at each rising edge of the access phase,
  // data and error are taken at the edge that sees it high, then the request drops
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read a register and compare both data and error response
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp, "read data");
    chk({31'h0, rerr}, {31'h0, err}, "read error flag");
  endtask

  // One-cycle update pulse from the control algorithm side
  task automatic upd(input logic [2:0] sel, input logic [31:0] d);
    @(posedge pclk);
    upd_valid <= 1'b1;
    upd_sel   <= sel;
    upd_data  <= d;
    @(posedge pclk);
    upd_valid <= 1'b0;
  endtask

  // Settle irq through its register stage before looking at it
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, exp}, "irq level");
  endtask

  // ---------------------------------------------------------------
  // Register tables shared by the scenarios
  // ---------------------------------------------------------------
  logic [15:0] ref_idx [4];  // The four reference word indices
  logic [31:0] ref_val [4];  // Boundary-style patterns, one per slot

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 4; i++)
      rd_chk(ba(ref_idx[i]), 32'h0000_0000, 1'b0);
    rd_chk(ba(motor_ref_pkg::IDX_DETECT_STATE), 32'h0000_0000, 1'b0);
    rd_chk(ba(motor_ref_pkg::IDX_IRQ_STATUS), 32'h0000_0000, 1'b0);
    rd_chk(ba(motor_ref_pkg::IDX_IRQ_MASK), 32'h0000_0000, 1'b0);
    irq_chk(1'b0);
    $display("test reset values done");
  endtask

  task automatic t_refs();
    for (int i = 0; i < 4; i++)
    begin
      upd(3'(i), ref_val[i]);
      rd_chk(ba(ref_idx[i]), ref_val[i], 1'b0);
      apb(1'b1, ba(ref_idx[i]), ~ref_val[i]);
      chk({31'h0, rerr}, 32'h0000_0000, "read-only write response");
      rd_chk(ba(ref_idx[i]), ref_val[i], 1'b0);
      rd_chk(ba(ref_idx[i]), ref_val[i], 1'b0);
    end
    // Updates to the unused slot numbers must not land anywhere
    for (int s = 5; s < 8; s++)
      upd(3'(s), 32'h1234_5678);
    for (int i = 0; i < 4; i++)
      rd_chk(ba(ref_idx[i]), ref_val[i], 1'b0);
    rd_chk(ba(motor_ref_pkg::IDX_IRQ_STATUS), 32'h0000_0004, 1'b0);
    apb(1'b1, ba(motor_ref_pkg::IDX_IRQ_STATUS), 32'h0000_0004);
    rd_chk(ba(motor_ref_pkg::IDX_IRQ_STATUS), 32'h0000_0000, 1'b0);
    $display("test reference words done");
  endtask

  task automatic t_detect();
    logic [15:0] codes [5];
    codes = '{motor_ref_pkg::DETECT_INIT, motor_ref_pkg::DETECT_STOP_CHECK,
              motor_ref_pkg::DETECT_DIRECTION, motor_ref_pkg::DETECT_DONE,
              motor_ref_pkg::DETECT_ERROR};
    // Junk in the upper half must never show through
    for (int i = 0; i < 5; i++)
    begin
      upd(motor_ref_pkg::SLOT_DETECT, {16'hdead, codes[i]});
      rd_chk(ba(motor_ref_pkg::IDX_DETECT_STATE), {16'h0000, codes[i]}, 1'b0);
    end
    rd_chk(ba(motor_ref_pkg::IDX_IRQ_STATUS), 32'h0000_0003, 1'b0);
    irq_chk(1'b0);
    apb(1'b1, ba(motor_ref_pkg::IDX_IRQ_MASK), 32'h0000_0001);
    rd_chk(ba(motor_ref_pkg::IDX_IRQ_MASK), 32'h0000_0001, 1'b0);
    irq_chk(1'b1);
    apb(1'b1, ba(motor_ref_pkg::IDX_IRQ_STATUS), 32'h0000_0001);
    rd_chk(ba(motor_ref_pkg::IDX_IRQ_STATUS), 32'h0000_0002, 1'b0);
    irq_chk(1'b0);
    apb(1'b1, ba(motor_ref_pkg::IDX_IRQ_STATUS), 32'h0000_0002);
    rd_chk(ba(motor_ref_pkg::IDX_IRQ_STATUS), 32'h0000_0000, 1'b0);
    rd_chk(ba(motor_ref_pkg::IDX_DETECT_STATE), 32'h0000_0004, 1'b0);
    $display("test detection state and interrupt done");
  endtask

  task automatic t_unmapped();
    rd_chk(16'h1524, 32'h0000_0000, 1'b1);
    rd_chk(16'h1521, 32'h0000_0000, 1'b1);
    apb(1'b1, 16'h1524, 32'hffff_ffff);
    chk({31'h0, rerr}, 32'h0000_0001, "unmapped write response");
    rd_chk(ba(ref_idx[0]), ref_val[0], 1'b0);
    $display("test unmapped addresses done");
  endtask

  // ---------------------------------------------------------------
  // Closing report, the only place the run ends
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 16'h0000;
    pwdata       = 32'h0000_0000;
    upd_valid    = 1'b0;
    upd_sel      = 3'h0;
    upd_data     = 32'h0000_0000;
    fail_count   = 0;
    total_checks = 0;
    ref_idx = '{motor_ref_pkg::IDX_OPEN_LOOP_TORQUE, motor_ref_pkg::IDX_CLOSED_SPEED,
                motor_ref_pkg::IDX_FLUX_CURRENT, motor_ref_pkg::IDX_TORQUE_CURRENT};
    ref_val = '{32'h8000_0001, 32'h0800_0000, 32'hffff_ffff, 32'h7fff_fffe};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_refs();
    t_detect();
    t_unmapped();
    conclude();
  end
endmodule
